// File: logic/tacd_pkg.sv
package tacd_pkg;

  // link engine states, gray along idle -> addr -> cmd -> done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_CMD  = 2'b11,
    ST_DONE = 2'b10
  } tacd_state_e;

  // --------------------------------------------------------------
  // byte layout
  // --------------------------------------------------------------
  localparam int ADDR_RW_BIT  = 0;
  localparam int CMD_FN_MSB   = 7;
  localparam int CMD_FN_LSB   = 4;
  localparam int CMD_PD_MSB   = 3;
  localparam int CMD_PD_LSB   = 2;
  localparam int CMD_RES_BIT  = 1;
  localparam int SET_FILT_BIT = 1;
  localparam int SET_PULL_BIT = 0;

  // --------------------------------------------------------------
  // bit counter marks
  // --------------------------------------------------------------
  localparam logic [3:0] CNT_LAST_BIT = 4'h7;
  localparam logic [3:0] CNT_ACK_SLOT = 4'h8;
  localparam logic [3:0] CNT_FN_DONE  = 4'h4;

  // --------------------------------------------------------------
  // function codes
  // --------------------------------------------------------------
  localparam logic [3:0]  FN_SETUP    = 4'hb;
  localparam logic [3:0]  FN_X_DRV    = 4'h8;
  localparam logic [3:0]  FN_Y_DRV    = 4'h9;
  localparam logic [3:0]  FN_YX_DRV   = 4'ha;
  localparam logic [3:0]  FN_MEAS_X   = 4'hc;
  localparam logic [3:0]  FN_MEAS_Y   = 4'hd;
  localparam logic [3:0]  FN_MEAS_Z1  = 4'he;
  localparam logic [3:0]  FN_MEAS_Z2  = 4'hf;
  // one bit per code that is never acknowledged
  localparam logic [15:0] FN_NOACK    = 16'h08ea;

  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [3:0] SETUP_RESET = 4'h0;
  localparam logic [1:0] PD_RESET    = 2'h0;
  localparam logic [3:0] DRV_OFF     = 4'h0;

  // drivers as {x_plus, x_minus, y_plus, y_minus}
  function automatic logic [3:0] tacd_drivers(input logic [3:0] fn);
    logic [3:0] d;
    d = DRV_OFF;
    if (fn == FN_X_DRV || fn == FN_MEAS_X)
      d = 4'hc;
    else if (fn == FN_Y_DRV || fn == FN_MEAS_Y)
      d = 4'h3;
    else if (fn == FN_YX_DRV || fn == FN_MEAS_Z1 || fn == FN_MEAS_Z2)
      d = 4'h6;
    return d;
  endfunction

endpackage

// File: logic/tacd_dec_if.sv
`timescale 1ns/1ns
interface tacd_dec_if;
  logic [7:0] cmd;
  logic [3:0] func;
  logic [1:0] pd;
  logic       res8;
  logic       setup;
  logic       valid;
  logic       xyz;

  modport dec (input cmd, output func, pd, res8, setup, valid, xyz);
  modport usr (output cmd, input func, pd, res8, setup, valid, xyz);
endinterface

// File: logic/tacd_cmd_decode.sv
`timescale 1ns/1ns
module tacd_cmd_decode
  import tacd_pkg::*;
(
  // command in, fields out
  tacd_dec_if.dec dif
);

  always_comb begin
    dif.func  = dif.cmd[CMD_FN_MSB:CMD_FN_LSB];
    dif.pd    = dif.cmd[CMD_PD_MSB:CMD_PD_LSB];
    dif.res8  = dif.cmd[CMD_RES_BIT];
    dif.setup = (dif.cmd[CMD_FN_MSB:CMD_FN_LSB] == FN_SETUP);
    dif.valid = ~FN_NOACK[dif.cmd[CMD_FN_MSB:CMD_FN_LSB]];
    dif.xyz   = (dif.cmd[CMD_FN_MSB:CMD_FN_LSB] >= FN_MEAS_X);
  end

endmodule

// File: logic/tacd_toggle_sync.sv
`timescale 1ns/1ns
module tacd_toggle_sync #(
  parameter int N = 5
) (
  // system clock
  input  wire logic         clock,
  input  wire logic         rst_n,
  // toggles from the link side, pulses out
  input  wire logic [N-1:0] toggle_in,
  output logic      [N-1:0] pulse_out
);

  logic [N-1:0] meta;
  logic [N-1:0] stable;
  logic [N-1:0] last;

  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        meta[i]   <= 1'b0;
        stable[i] <= 1'b0;
        last[i]   <= 1'b0;
      end else begin
        meta[i]   <= toggle_in[i];
        stable[i] <= meta[i];
        last[i]   <= stable[i];
      end
    end
    assign pulse_out[i] = stable[i] ^ last[i];
  end

endmodule

// File: logic/tacd_top.sv
// Operation
// - seven-bit address, upper five bits a fixed device prefix
// - lowest two address bits come from the address select pins
// - select pins are read again for every address byte
// - address latched on SCL falling edge after direction bit
// - address bit 0 set means master read, clear means write
// - acknowledge address only after all bits match
// - command bits 7..4 select converter function and drivers
// - bits 3..2 choose converter power and pen interrupt enable
// - new power-down mode takes effect once command completes
// - bit 1 picks 8-bit when set, 12-bit when clear; bit 0 ignored
// - power_down_low_bit keeps X/Y/Z drivers on after conversion
// - setup code stores low four bits; only reset or a later setup code changes them
// - setup bit 1 set bypasses median_average_filter
// - setup bit 0 picks 90k pull-up, clear picks 50k
// - only the first command byte of a write is acknowledged
// - channel follows function bits; acquisition at next fall
`timescale 1ns/1ns
module tacd_top
  import tacd_pkg::*;
#(
  // device type prefix, value arbitrary
  parameter logic [4:0] DEV_PREFIX = 5'h0b
) (
  // system clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // two-wire link
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [1:0] addr_select_pins,
  // link-side status
  output logic [6:0]      slave_address,
  output logic [3:0]      channel_select,
  // converter control
  output logic [3:0]      function_select_field,
  output logic [1:0]      power_down_field,
  output logic            resolution_8bit,
  output logic            acq_start,
  output logic            read_request,
  output logic [3:0]      driver_enable,
  output logic            adc_on,
  output logic            pen_irq_enable,
  output logic            cmd_busy,
  // static setup
  output logic [3:0]      setup_config_bits,
  output logic            filter_bypass,
  output logic            pullup_90k
);

  // ------------------------------------------------------------
  // bus conditions, clocked by the data line itself
  // ------------------------------------------------------------
  logic start_tgl;
  logic stop_tgl;

  always_ff @(negedge sda_in or negedge rst_n) begin
    if (!rst_n)
      start_tgl <= 1'b0;
    else if (scl)
      start_tgl <= ~start_tgl;
  end

  always_ff @(posedge sda_in or negedge rst_n) begin
    if (!rst_n)
      stop_tgl <= 1'b0;
    else if (scl)
      stop_tgl <= ~stop_tgl;
  end

  // ------------------------------------------------------------
  // link domain: sampling on rising SCL
  // ------------------------------------------------------------
  tacd_state_e state;
  logic [3:0]  bit_cnt;
  logic [6:0]  shreg;
  logic [7:0]  rx_byte;
  logic [1:0]  pin_meta;
  logic [1:0]  pin_sync;
  logic        start_seen;
  logic        stop_seen;
  logic        new_start;
  logic        new_stop;
  logic        addr_hit;
  logic        addr_rw;
  logic [6:0]  addr_byte;
  logic        first_cmd;
  logic        ack_req;
  logic [7:0]  cmd_byte;
  logic        cmd_tgl;
  logic        read_tgl;
  logic        acq_tgl;

  assign rx_byte = {shreg, sda_in};
  // condition toggles have been stable since SDA moved with SCL high
  assign new_start = start_tgl != start_seen;
  assign new_stop  = stop_tgl != stop_seen;

  // select pins are straps, still passed through two flops
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 2'h0;
      pin_sync <= 2'h0;
    end else begin
      pin_meta <= addr_select_pins;
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      start_seen <= 1'b0;
      stop_seen  <= 1'b0;
    end else begin
      start_seen <= start_tgl;
      stop_seen  <= stop_tgl;
    end
  end

  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n)
      shreg <= 7'h00;
    else if (new_start)
      shreg <= {6'h00, sda_in};
    else
      shreg <= rx_byte[6:0];
  end

  // frame sequencing
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      state   <= ST_IDLE;
      bit_cnt <= 4'h0;
    end else if (new_start) begin
      state   <= ST_ADDR;
      bit_cnt <= 4'h1;
    end else if (new_stop) begin
      state   <= ST_IDLE;
      bit_cnt <= 4'h0;
    end else if (state == ST_ADDR || state == ST_CMD) begin
      if (bit_cnt == CNT_ACK_SLOT) begin
        bit_cnt <= 4'h0;
        if (state == ST_ADDR)
          state <= (addr_hit && !addr_rw) ? ST_CMD : ST_DONE;
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // address compare on the eighth bit
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      addr_hit  <= 1'b0;
      addr_rw   <= 1'b0;
      addr_byte <= 7'h00;
    end else if (new_start) begin
      addr_hit <= 1'b0;
    end else if (state == ST_ADDR && bit_cnt == CNT_LAST_BIT) begin
      addr_hit  <= rx_byte[7:3] == DEV_PREFIX
                && rx_byte[2:1] == pin_sync;
      addr_rw   <= rx_byte[ADDR_RW_BIT];
      addr_byte <= rx_byte[7:1];
    end
  end

  // acknowledge decision, dropped at the ack clock
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n)
      ack_req <= 1'b0;
    else if (new_start || new_stop)
      ack_req <= 1'b0;
    else if (state == ST_ADDR && bit_cnt == CNT_LAST_BIT)
      ack_req <= rx_byte[7:3] == DEV_PREFIX
              && rx_byte[2:1] == pin_sync;
    else if (state == ST_CMD && bit_cnt == CNT_LAST_BIT)
      ack_req <= first_cmd
              && !FN_NOACK[rx_byte[CMD_FN_MSB:CMD_FN_LSB]];
    else
      ack_req <= 1'b0;
  end

  // only the first command byte of a write counts
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n)
      first_cmd <= 1'b0;
    else if (new_start || new_stop)
      first_cmd <= 1'b0;
    else if (state == ST_ADDR && bit_cnt == CNT_ACK_SLOT)
      first_cmd <= addr_hit && !addr_rw;
    else if (state == ST_CMD && bit_cnt == CNT_LAST_BIT)
      first_cmd <= 1'b0;
  end

  // command byte handed over with a toggle
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      cmd_byte <= 8'h00;
      cmd_tgl  <= 1'b0;
    end else if (state == ST_CMD && bit_cnt == CNT_LAST_BIT
                 && first_cmd && !new_start && !new_stop) begin
      cmd_byte <= rx_byte;
      cmd_tgl  <= ~cmd_tgl;
    end
  end

  // input channel follows the function bits as they arrive
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n)
      channel_select <= 4'h0;
    else if (state == ST_CMD && first_cmd && bit_cnt < CNT_FN_DONE
             && !new_start && !new_stop)
      channel_select <= {channel_select[2:0], sda_in};
  end

  // ------------------------------------------------------------
  // link domain: driving on falling SCL
  // ------------------------------------------------------------
  assign sda_out = 1'b0;

  always_ff @(negedge scl or negedge rst_n) begin
    if (!rst_n)
      sda_oe <= 1'b0;
    else
      sda_oe <= ack_req;
  end

  always_ff @(negedge scl or negedge rst_n) begin
    if (!rst_n) begin
      slave_address <= 7'h00;
      read_tgl      <= 1'b0;
    end else if (state == ST_ADDR && bit_cnt == CNT_ACK_SLOT) begin
      slave_address <= addr_byte;
      if (addr_hit && addr_rw)
        read_tgl <= ~read_tgl;
    end
  end

  always_ff @(negedge scl or negedge rst_n) begin
    if (!rst_n)
      acq_tgl <= 1'b0;
    else if (state == ST_CMD && first_cmd && bit_cnt == CNT_FN_DONE
             && !FN_NOACK[channel_select])
      acq_tgl <= ~acq_tgl;
  end

  // ------------------------------------------------------------
  // crossing into the system clock
  // ------------------------------------------------------------
  logic [4:0] evt;
  logic       start_pulse;
  logic       stop_pulse;
  logic       cmd_pulse;
  logic       frame_end;

  tacd_toggle_sync #(.N(5)) u_sync (
    .clock     (clock),
    .rst_n     (rst_n),
    .toggle_in ({read_tgl, acq_tgl, cmd_tgl, stop_tgl, start_tgl}),
    .pulse_out (evt)
  );

  assign start_pulse  = evt[0];
  assign stop_pulse   = evt[1];
  assign cmd_pulse    = evt[2];
  assign acq_start    = evt[3];
  assign read_request = evt[4];
  // a write ends with a stop or a repeated start
  assign frame_end    = start_pulse | stop_pulse;

  // ------------------------------------------------------------
  // command decode in the system domain
  // ------------------------------------------------------------
  tacd_dec_if dif ();

  assign dif.cmd = cmd_byte;

  tacd_cmd_decode u_dec (
    .dif (dif)
  );

  logic [1:0] pd_pending;
  logic       xyz_pending;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      setup_config_bits <= SETUP_RESET;
    else if (cmd_pulse && dif.setup)
      setup_config_bits <= cmd_byte[3:0];
  end

  assign filter_bypass = setup_config_bits[SET_FILT_BIT];
  assign pullup_90k    = setup_config_bits[SET_PULL_BIT];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      function_select_field <= 4'h0;
      resolution_8bit       <= 1'b0;
      pd_pending            <= PD_RESET;
      xyz_pending           <= 1'b0;
    end else if (cmd_pulse && dif.valid) begin
      function_select_field <= dif.func;
      resolution_8bit       <= dif.res8;
      pd_pending            <= dif.pd;
      xyz_pending           <= dif.xyz;
    end
  end

  // new power mode only once the write has finished
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_busy         <= 1'b0;
      power_down_field <= PD_RESET;
      adc_on           <= 1'b0;
      pen_irq_enable   <= 1'b1;
    end else if (cmd_pulse && dif.valid) begin
      cmd_busy <= 1'b1;
    end else if (frame_end && cmd_busy) begin
      cmd_busy         <= 1'b0;
      power_down_field <= pd_pending;
      adc_on           <= pd_pending[0];
      pen_irq_enable   <= ~pd_pending[0];
    end
  end

  // drivers on at acquisition, kept after it on request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      driver_enable <= DRV_OFF;
    else if (acq_start)
      driver_enable <= tacd_drivers(channel_select);
    else if (frame_end && cmd_busy
             && !(pd_pending[0] && xyz_pending))
      driver_enable <= DRV_OFF;
  end

endmodule

// File: verification/tacd_top_properties.sv
`timescale 1ns/1ns
module tacd_checker (
  // clocks and reset
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       scl,
  // watched outputs
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [1:0] power_down_field,
  input wire logic       adc_on,
  input wire logic       pen_irq_enable,
  input wire logic [3:0] setup_config_bits,
  input wire logic       filter_bypass,
  input wire logic       pullup_90k,
  input wire logic       acq_start,
  input wire logic       read_request,
  input wire logic       cmd_busy,
  input wire logic [3:0] driver_enable
);
  // ------------------------------------------------------------
  // link side
  // ------------------------------------------------------------
  a_ack_one_slot: assert property (
    @(posedge scl) disable iff (!rst_n) sda_oe |=> !sda_oe)
    else $error("acknowledge held past one bit slot");
  a_pull_low_only: assert property (
    @(posedge clock) disable iff (!rst_n) sda_out == 1'b0)
    else $error("data line driven high");
  // ------------------------------------------------------------
  // system side
  // ------------------------------------------------------------
  a_mode_outputs: assert property (
    @(posedge clock) disable iff (!rst_n) $stable(power_down_field)
    |-> adc_on == power_down_field[0]
        && pen_irq_enable == !power_down_field[0])
    else $error("power mode outputs disagree with mode");
  a_mode_held_busy: assert property (
    @(posedge clock) disable iff (!rst_n)
    cmd_busy && $past(cmd_busy) |-> $stable(power_down_field))
    else $error("power mode changed before completion");
  a_drivers_park: assert property (
    @(posedge clock) disable iff (!rst_n)
    $fell(cmd_busy) && !power_down_field[0] |-> ##[0:2] driver_enable == 4'h0)
    else $error("drivers left on after completion");
  a_filter_view: assert property (
    @(posedge clock) disable iff (!rst_n) $stable(setup_config_bits)
    |-> filter_bypass == setup_config_bits[1])
    else $error("filter bypass disagrees with setup");
  a_pullup_view: assert property (
    @(posedge clock) disable iff (!rst_n) $stable(setup_config_bits)
    |-> pullup_90k == setup_config_bits[0])
    else $error("pull-up select disagrees with setup");
  a_acq_pulse: assert property (
    @(posedge clock) disable iff (!rst_n) acq_start |=> !acq_start)
    else $error("acquisition pulse longer than one clock");
  a_read_pulse: assert property (
    @(posedge clock) disable iff (!rst_n) read_request |=> !read_request)
    else $error("read pulse longer than one clock");
  c_acq: cover property (@(posedge clock) acq_start);
  c_read: cover property (@(posedge clock) read_request);
  c_setup: cover property (@(posedge clock) $changed(setup_config_bits));
  c_ack: cover property (@(posedge scl) sda_oe);
endmodule

bind tacd_top tacd_checker u_chk (.clock, .rst_n, .scl, .sda_out, .sda_oe,
  .power_down_field, .adc_on, .pen_irq_enable, .setup_config_bits,
  .filter_bypass, .pullup_90k, .acq_start, .read_request, .cmd_busy,
  .driver_enable);

// File: verification/tacd_host_model.sv
`timescale 1ns/1ns
module tacd_host_model (
  // two-wire link, data released high by pull-up
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_wire
);
  localparam int QTR = 16;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // start or repeated start, leaves scl low
  task automatic start();
    sda_drv = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_drv = 1'b0;
    #QTR scl = 1'b0;
  endtask
  // one byte msb first, then the acknowledge slot
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #QTR sda_drv = b[i];
      #QTR scl = 1'b1;
      #(2*QTR) scl = 1'b0;
    end
    #QTR sda_drv = 1'b1;
    #QTR scl = 1'b1;
    #QTR ack = ~sda_wire;
    #QTR scl = 1'b0;
  endtask
  // stop, clock stands high afterwards
  task automatic stop();
    #QTR sda_drv = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_drv = 1'b1;
    #QTR;
  endtask
endmodule

// File: verification/touch_adc_i2c_command_decoder_tb.sv
`timescale 1ns/1ns
module touch_adc_i2c_command_decoder_tb;
  import tacd_pkg::*;
  // device prefix, value arbitrary
  localparam logic [4:0] PFX = 5'h16;
  logic       clock, rst_n, scl, sda_drv, sda_in, sda_out, sda_oe;
  logic [1:0] addr_select_pins, power_down_field, exp_pd;
  logic [6:0] slave_address;
  logic [3:0] channel_select, function_select_field, driver_enable;
  logic [3:0] setup_config_bits, exp_fn, exp_drv;
  logic       resolution_8bit, acq_start, read_request, adc_on, ok;
  logic       pen_irq_enable, cmd_busy, filter_bypass, pullup_90k, exp_res;
  logic [7:0] cb;
  int         n_errors, compares, n_acq, n_rd, exp_acq;

  tacd_top #(.DEV_PREFIX(PFX)) u_dut (.clock, .rst_n, .scl, .sda_in,
    .sda_out, .sda_oe, .addr_select_pins, .slave_address, .channel_select,
    .function_select_field, .power_down_field, .resolution_8bit,
    .acq_start, .read_request, .driver_enable, .adc_on, .pen_irq_enable,
    .cmd_busy, .setup_config_bits, .filter_bypass, .pullup_90k);
  tacd_host_model u_host (.scl, .sda_drv, .sda_wire(sda_in));

  assign sda_in = sda_drv & ~(sda_oe & ~sda_out);
  always #10 clock = ~clock;
  // pulses stand one full clock, so the falling edge sees each once
  always @(negedge clock) begin
    if (acq_start === 1'b1) n_acq++;
    if (read_request === 1'b1) n_rd++;
  end

  // ------------------------------------------------------------
  // compares and transfers
  // ------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp, input string w);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %b exp %b", $time, w, got, exp);
    end
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp,
                         input string w);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] ab, input logic ea, input int ncmd,
                      input logic [7:0] c, input logic ec);
    logic a;
    @(negedge clock);
    u_host.start();
    u_host.send(ab, a);
    chk_bit(a, ea, "address ack");
    for (int k = 0; k < ncmd; k++) begin
      u_host.send(c, a);
      chk_bit(a, ec && k == 0, "command ack");
    end
    repeat (6) @(negedge clock);
    chk_val(8'(power_down_field), 8'(exp_pd), "mode before end");
    chk_bit(cmd_busy, ec, "busy before end");
    u_host.stop();
    repeat (6) @(negedge clock);
    chk_bit(cmd_busy, 1'b0, "busy after end");
  endtask
  task automatic complete_run();
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    addr_select_pins = 2'b10;
    {n_errors, compares, n_acq, n_rd, exp_acq} = '0;
    {exp_pd, exp_drv} = '0;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    chk_val(8'(setup_config_bits), 8'h00, "setup reset");
    chk_bit(pullup_90k, 1'b0, "pull-up reset");
    chk_bit(pen_irq_enable, 1'b1, "pen irq reset");
    xfer({PFX, 2'b10, 1'b0}, 1, 1, {FN_MEAS_X, 4'h0}, 1);
    chk_val(8'(slave_address), 8'({PFX, 2'b10}), "address");
    chk_val(8'(channel_select), 8'(FN_MEAS_X), "channel");
    xfer({PFX ^ 5'h01, 2'b10, 1'b0}, 0, 0, 8'h00, 0);
    chk_val(8'(slave_address), 8'({PFX ^ 5'h01, 2'b10}), "address");
    xfer({PFX, 2'b01, 1'b0}, 0, 0, 8'h00, 0);
    addr_select_pins = 2'b01;
    xfer({PFX, 2'b01, 1'b0}, 1, 2, {FN_MEAS_Y, 4'h0}, 1);
    exp_acq = 2;
    xfer({PFX, 2'b01, 1'b1}, 1, 0, 8'h00, 0);
    chk_val(8'(n_rd), 8'h01, "read pulses");
    for (int c = 0; c < 16; c++) begin
      cb = (c == 11) ? 8'hb2 : {4'(c), 2'(c), ~c[0], 1'b1};
      ok = !(c inside {1, 3, 5, 6, 7, 11});
      xfer({PFX, 2'b01, 1'b0}, 1, 1, cb, ok);
      if (ok) begin
        exp_pd = 2'(c);
        exp_fn = 4'(c);
        exp_res = ~c[0];
        exp_acq++;
        exp_drv = (c == 13) ? 4'h3 : (c == 15) ? 4'h6 : 4'h0;
      end
      chk_val(8'(function_select_field), 8'(exp_fn), "function");
      chk_val(8'(power_down_field), 8'(exp_pd), "mode");
      chk_bit(adc_on, exp_pd[0], "converter on");
      chk_bit(pen_irq_enable, ~exp_pd[0], "pen irq");
      chk_bit(resolution_8bit, exp_res, "resolution");
      chk_val(8'(driver_enable), 8'(exp_drv), "drivers");
    end
    chk_val(8'(setup_config_bits), 8'h02, "setup kept");
    chk_bit(filter_bypass, 1'b1, "filter bypass");
    // command closed by a repeated start into a read
    @(negedge clock);
    u_host.start();
    u_host.send({PFX, 2'b01, 1'b0}, ok);
    u_host.send({FN_MEAS_X, 4'h4}, ok);
    chk_bit(ok, 1'b1, "command ack");
    repeat (6) @(negedge clock);
    chk_bit(cmd_busy, 1'b1, "busy before restart");
    u_host.start();
    u_host.send({PFX, 2'b01, 1'b1}, ok);
    chk_bit(ok, 1'b1, "read address ack");
    repeat (6) @(negedge clock);
    exp_pd = 2'b01;
    exp_acq++;
    chk_val(8'(power_down_field), 8'(exp_pd), "mode after restart");
    chk_bit(pen_irq_enable, 1'b0, "pen irq off");
    chk_val(8'(driver_enable), 8'h0c, "drivers kept");
    chk_val(8'(n_rd), 8'h02, "read pulses");
    u_host.stop();
    repeat (6) @(negedge clock);
    xfer({PFX, 2'b01, 1'b0}, 1, 1, 8'hb1, 0);
    chk_val(8'(setup_config_bits), 8'h01, "setup");
    chk_bit(filter_bypass, 1'b0, "filter used");
    chk_bit(pullup_90k, 1'b1, "pull-up 90k");
    chk_val(8'(n_acq), 8'(exp_acq), "acquisitions");
    rst_n = 1'b0;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    chk_val(8'(setup_config_bits), 8'h00, "setup after reset");
    chk_val(8'(power_down_field), 8'h00, "mode after reset");
    chk_bit(pen_irq_enable, 1'b1, "pen irq after reset");
    chk_val(8'(driver_enable), 8'h00, "drivers after reset");
    complete_run();
  end

  // hang guard, the whole run needs well under 100 us
  initial begin
    #300000;
    $display("FAIL %0t watchdog expired", $time);
    n_errors++;
    complete_run();
  end
endmodule
